// [hdl/txd_pkg.sv]
// Shared constants for the transmit descriptor parser
// Function
// - Hand-over flag bit 31 set means device owns descriptor; clear means host owns.
// - Device clears hand-over flag after the buffer data has been transmitted.
// - Ring-end bit 30 makes the pointer return to the first descriptor after sending.
// - First-segment bit 29 marks the descriptor starting a new packet.
// - Last-segment bit 28 marks the descriptor ending the packet.
// - Bit 27 requests segmentation; clear means normal layout with sum requests.
// - Normal layout bit 18 requests the IP header checksum.
// - Normal layout bit 17 requests the UDP checksum.
// - Normal layout bit 16 requests the TCP checksum.
// - Byte count in first word bits 15:0; send exactly that many bytes.
// - Second word bit 17 inserts type 0x8100 then the two tag-control bytes.
// - Tag insert clear means the packet is sent unmodified.
// - Tag control holds split 12-bit VLAN id, 3-bit priority, canonical bit.
// - Buffer address low word at offset 8, high word at offset 12.
// - With segmentation, segment size limit comes from first word bits 26:16.
// - After sending, descriptor holds status form: flag clear, ring and segment bits kept.
package txd_pkg;

	// Descriptor word 0 fields
	localparam int OWN_BIT        = 31;
	localparam int RING_END_BIT   = 30;
	localparam int FIRST_SEG_BIT  = 29;
	localparam int LAST_SEG_BIT   = 28;
	localparam int SEG_OFFLOAD_BIT = 27;
	localparam int MSS_MSB        = 26;
	localparam int MSS_LSB        = 16;
	localparam int IP_SUM_BIT     = 18;
	localparam int UDP_SUM_BIT    = 17;
	localparam int TCP_SUM_BIT    = 16;
	localparam int LEN_MSB        = 15;

	// Descriptor word 1 fields
	localparam int TAG_INSERT_BIT = 17;
	localparam int VID_LOW_LSB    = 8;
	localparam int USER_PRIORITY_LSB       = 5;
	localparam int CFI_BIT        = 4;

	// Descriptor geometry, byte offsets of the words
	localparam logic [7:0] DESC_BYTES   = 8'h10;
	localparam logic [7:0] WORD_LEN_OFS = 8'h00;
	localparam logic [7:0] WORD_TAG_OFS = 8'h04;
	localparam logic [7:0] WORD_ALO_OFS = 8'h08;
	localparam logic [7:0] WORD_AHI_OFS = 8'h0C;

	localparam logic [15:0] TAG_PROTO_ID = 16'h8100;
	localparam logic [15:0] MIN_BUF_LEN  = 16'h0004;

	// Register map (byte addresses)
	localparam logic [7:0] REG_BASE_LO = 8'h00;
	localparam logic [7:0] REG_BASE_HI = 8'h04;
	localparam logic [7:0] REG_CTRL    = 8'h08;
	localparam logic [7:0] REG_POLL    = 8'h0C;
	localparam logic [7:0] REG_STATUS  = 8'h10;

	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_SEND,
		ST_WBACK
	} fsm_t;

endpackage

// [hdl/txd_reg_if.sv]
// Carrier between the register slave and the descriptor engine
`timescale 1ns/100ps
interface txd_reg_if #(parameter int IDX_W = 8);
	logic [63:0]    ring_base;
	logic           enable;
	logic           poll;
	logic [IDX_W-1:0] cur_idx;
	logic           busy;
	logic           stopped;
	logic           short_seen;

	modport regs (output ring_base, enable, poll, input cur_idx, busy, stopped, short_seen);
	modport core (input ring_base, enable, poll, output cur_idx, busy, stopped, short_seen);
endinterface

// [hdl/txd_axil_regs.sv]
// AXI4-Lite register slave for the descriptor engine
`timescale 1ns/100ps
module txd_axil_regs
	import txd_pkg::*;
#(
	parameter int IDX_W = 8
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// AXI4-Lite
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Engine side
	txd_reg_if.regs          rif
);
	logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [63:0] base_q, base_d;
	logic        en_q, en_d, poll_q, poll_d;
	logic [31:0] wmask;

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		base_d    = base_q;
		en_d      = en_q;
		poll_d    = 1'b0;
		wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
		if (i_awvalid && !aw_have_q && !bvalid_q) begin
			aw_have_d = 1'b1;
			awaddr_d  = i_awaddr;
		end
		if (i_wvalid && !w_have_q && !bvalid_q) begin
			w_have_d = 1'b1;
			wdata_d  = i_wdata;
			wstrb_d  = i_wstrb;
		end
		if (aw_have_q && w_have_q) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OK;
			unique case (awaddr_q)
				REG_BASE_LO: base_d[31:0]  = (base_q[31:0] & ~wmask) | (wdata_q & wmask);
				REG_BASE_HI: base_d[63:32] = (base_q[63:32] & ~wmask) | (wdata_q & wmask);
				REG_CTRL:    if (wstrb_q[0]) en_d = wdata_q[0];
				REG_POLL:    poll_d = wstrb_q[0] & wdata_q[0];
				REG_STATUS:  ;
				default:     bresp_d = RESP_ERR;
			endcase
		end
		if (bvalid_q && i_bready) begin
			bvalid_d = 1'b0;
		end
		if (rvalid_q && i_rready) begin
			rvalid_d = 1'b0;
		end else if (i_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OK;
			unique case (i_araddr)
				REG_BASE_LO: rdata_d = base_q[31:0];
				REG_BASE_HI: rdata_d = base_q[63:32];
				REG_CTRL:    rdata_d = {31'h0, en_q};
				REG_POLL:    rdata_d = 32'h0;
				REG_STATUS:  rdata_d = {13'h0, rif.short_seen, rif.stopped, rif.busy,
					{(16 - IDX_W){1'b0}}, rif.cur_idx};
				default: begin
					rdata_d = 32'h0;
					rresp_d = RESP_ERR;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OK;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OK;
			rdata_q   <= 32'h0;
			base_q    <= {BASE_RST, BASE_RST};
			en_q      <= 1'b0;
			poll_q    <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			base_q    <= base_d;
			en_q      <= en_d;
			poll_q    <= poll_d;
		end
	end

	assign o_awready     = i_awvalid && !aw_have_q && !bvalid_q;
	assign o_wready      = i_wvalid && !w_have_q && !bvalid_q;
	assign o_bvalid      = bvalid_q;
	assign o_bresp       = bresp_q;
	assign o_arready     = i_arvalid && !rvalid_q;
	assign o_rvalid      = rvalid_q;
	assign o_rresp       = rresp_q;
	assign o_rdata       = rdata_q;
	assign rif.ring_base = base_q;
	assign rif.enable    = en_q;
	assign rif.poll      = poll_q;
endmodule

// [hdl/tx_descriptor_parser.sv]
// Transmit descriptor fetch, decode and write-back engine
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module tx_descriptor_parser
	import txd_pkg::*;
#(
	parameter int IDX_W = 8
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// AXI4-Lite register bus
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Descriptor memory port
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic [63:0]      o_mem_addr,
	output logic [31:0]      o_mem_wdata,
	input  wire logic        i_mem_ack,
	input  wire logic [31:0] i_mem_rdata,
	// Segment to transmit datapath
	output logic             o_seg_valid,
	output logic [63:0]      o_seg_addr,
	output logic [15:0]      o_seg_len,
	output logic             o_first_segment_marker,
	output logic             o_last_segment_marker,
	output logic             o_segmentation_offload_request,
	output logic [10:0]      o_segment_size_limit,
	output logic             o_ip_header_sum_request,
	output logic             o_datagram_sum_request,
	output logic             o_stream_sum_request,
	output logic             o_tag_insert_enable,
	output logic [15:0]      o_tag_proto_id,
	output logic [15:0]      o_tag_control_info,
	output logic [11:0]      o_vlan_id,
	output logic [2:0]       o_user_priority,
	output logic             o_canonical_format_bit,
	input  wire logic        i_seg_done
);
	initial begin
		// Status word keeps at least one pad bit above the index
		if (IDX_W < 1 || IDX_W > 15) begin
			$error("IDX_W must lie in 1..15");
		end
	end

	txd_reg_if #(.IDX_W(IDX_W)) rif ();

	txd_axil_regs #(.IDX_W(IDX_W)) u_regs (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_awaddr  (i_awaddr),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.o_bresp   (o_bresp),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.i_araddr  (i_araddr),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.rif       (rif)
	);

	fsm_t             state_q, state_d;
	logic [IDX_W-1:0] idx_q, idx_d;
	logic [1:0]       word_q, word_d;
	logic [31:0]      w0_q, w0_d, w1_q, w1_d, alo_q, alo_d, ahi_q, ahi_d;
	logic             req_q, req_d, we_q, we_d;
	logic [63:0]      maddr_q, maddr_d;
	logic [31:0]      mwdata_q, mwdata_d;
	logic             poll_pend_q, poll_pend_d;
	logic             stopped_q, stopped_d, short_q, short_d;
	logic             seg_valid_q, seg_valid_d;
	logic [63:0]      desc_addr;
	logic [7:0]       word_ofs;

	// Descriptor base: ring base plus index times descriptor size
	assign desc_addr = rif.ring_base + {{(56 - IDX_W){1'b0}}, idx_q, 8'h00} / {56'h0, DESC_BYTES};

	always_comb begin
		unique case (word_q)
			2'h0: word_ofs = WORD_LEN_OFS;
			2'h1: word_ofs = WORD_TAG_OFS;
			2'h2: word_ofs = WORD_ALO_OFS;
			2'h3: word_ofs = WORD_AHI_OFS;
		endcase
	end

	always_comb begin
		state_d     = state_q;
		idx_d       = idx_q;
		word_d      = word_q;
		w0_d        = w0_q;
		w1_d        = w1_q;
		alo_d       = alo_q;
		ahi_d       = ahi_q;
		req_d       = req_q;
		we_d        = we_q;
		maddr_d     = maddr_q;
		mwdata_d    = mwdata_q;
		stopped_d   = stopped_q;
		short_d     = short_q;
		seg_valid_d = seg_valid_q;
		// A poll arriving while the pending bit is consumed is kept
		poll_pend_d = poll_pend_q;
		unique case (state_q)
			ST_IDLE: begin
				if (rif.enable && poll_pend_q) begin
					poll_pend_d = 1'b0;
					stopped_d   = 1'b0;
					word_d      = 2'h0;
					state_d     = ST_FETCH;
				end
			end
			ST_FETCH: begin
				// Request is dropped for a cycle between words
				if (!req_q) begin
					req_d   = 1'b1;
					we_d    = 1'b0;
					maddr_d = desc_addr + {56'h0, word_ofs};
				end else if (i_mem_ack) begin
					req_d = 1'b0;
					unique case (word_q)
						2'h0: w0_d  = i_mem_rdata;
						2'h1: w1_d  = i_mem_rdata;
						2'h2: alo_d = i_mem_rdata;
						2'h3: ahi_d = i_mem_rdata;
					endcase
					if (word_q == 2'h0 && !i_mem_rdata[OWN_BIT]) begin
						// Host-owned: park on this index until polled again
						stopped_d = 1'b1;
						state_d   = ST_IDLE;
					end else if (word_q == 2'h3) begin
						seg_valid_d = 1'b1;
						if (w0_q[LEN_MSB:0] < MIN_BUF_LEN) begin
							short_d = 1'b1;
						end
						state_d = ST_SEND;
					end else begin
						word_d = word_q + 2'h1;
					end
				end
			end
			ST_SEND: begin
				if (i_seg_done) begin
					seg_valid_d = 1'b0;
					req_d       = 1'b1;
					we_d        = 1'b1;
					maddr_d     = desc_addr;
					// Status form: flag cleared, ring and segment bits kept
					mwdata_d = {1'b0, w0_q[RING_END_BIT], w0_q[FIRST_SEG_BIT],
						w0_q[LAST_SEG_BIT], 28'h0};
					state_d = ST_WBACK;
				end
			end
			ST_WBACK: begin
				if (i_mem_ack) begin
					req_d = 1'b0;
					we_d  = 1'b0;
					if (w0_q[RING_END_BIT]) begin
						idx_d = '0;
					end else begin
						idx_d = idx_q + {{(IDX_W - 1){1'b0}}, 1'b1};
					end
					word_d  = 2'h0;
					state_d = rif.enable ? ST_FETCH : ST_IDLE;
				end
			end
		endcase
		if (rif.poll) begin
			poll_pend_d = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q     <= ST_IDLE;
			idx_q       <= '0;
			word_q      <= 2'h0;
			w0_q        <= 32'h0;
			w1_q        <= 32'h0;
			alo_q       <= 32'h0;
			ahi_q       <= 32'h0;
			req_q       <= 1'b0;
			we_q        <= 1'b0;
			maddr_q     <= 64'h0;
			mwdata_q    <= 32'h0;
			poll_pend_q <= 1'b0;
			stopped_q   <= 1'b0;
			short_q     <= 1'b0;
			seg_valid_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			idx_q       <= idx_d;
			word_q      <= word_d;
			w0_q        <= w0_d;
			w1_q        <= w1_d;
			alo_q       <= alo_d;
			ahi_q       <= ahi_d;
			req_q       <= req_d;
			we_q        <= we_d;
			maddr_q     <= maddr_d;
			mwdata_q    <= mwdata_d;
			poll_pend_q <= poll_pend_d;
			stopped_q   <= stopped_d;
			short_q     <= short_d;
			seg_valid_q <= seg_valid_d;
		end
	end

	// Decoded segment fields, held steady while o_seg_valid is high
	logic        lso;
	logic        tag_on;
	assign lso    = w0_q[SEG_OFFLOAD_BIT];
	assign tag_on = w1_q[TAG_INSERT_BIT];

	assign o_mem_req                      = req_q;
	assign o_mem_we                       = we_q;
	assign o_mem_addr                     = maddr_q;
	assign o_mem_wdata                    = mwdata_q;
	assign o_seg_valid                    = seg_valid_q;
	assign o_seg_addr                     = {ahi_q, alo_q};
	assign o_seg_len                      = w0_q[LEN_MSB:0];
	assign o_first_segment_marker         = w0_q[FIRST_SEG_BIT];
	assign o_last_segment_marker          = w0_q[LAST_SEG_BIT];
	assign o_segmentation_offload_request = lso;
	// Normal-layout bits 26:19 are never looked at
	assign o_segment_size_limit = lso ? w0_q[MSS_MSB:MSS_LSB] : 11'h000;
	assign o_ip_header_sum_request = !lso && w0_q[IP_SUM_BIT];
	assign o_datagram_sum_request  = !lso && w0_q[UDP_SUM_BIT];
	assign o_stream_sum_request    = !lso && w0_q[TCP_SUM_BIT];
	assign o_tag_insert_enable     = tag_on;
	assign o_tag_proto_id          = tag_on ? TAG_PROTO_ID : 16'h0000;
	assign o_tag_control_info      = tag_on ? w1_q[15:0] : 16'h0000;
	assign o_vlan_id = tag_on ? {w1_q[3:0], w1_q[VID_LOW_LSB +: 8]} : 12'h000;
	assign o_user_priority        = tag_on ? w1_q[USER_PRIORITY_LSB +: 3] : 3'h0;
	assign o_canonical_format_bit = tag_on && w1_q[CFI_BIT];

	assign rif.cur_idx    = idx_q;
	assign rif.busy       = (state_q != ST_IDLE);
	assign rif.stopped    = stopped_q;
	assign rif.short_seen = short_q;
endmodule

// [test/txd_mem_model.sv]
// Behavioural descriptor memory on the engine's fetch and write-back port
`timescale 1ns/100ps
module txd_mem_model (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// Engine memory port
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [63:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_slow,
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	logic [31:0] mem [16];
	logic [1:0]  wait_q;
	logic        gap_q;

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			wait_q <= 2'h0;
			gap_q <= 1'b0;
			o_rdata <= 32'h0;
		end else begin
			gap_q <= o_ack;
			o_ack <= 1'b0;
			// Data line is not driven outside ack, so keep it moving
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack && !gap_q) begin
				if (!i_slow || wait_q == 2'h3) begin
					o_ack <= 1'b1;
					wait_q <= 2'h0;
					if (i_we)
						mem[i_addr[5:2]] <= i_wdata;
					else
						o_rdata <= mem[i_addr[5:2]];
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule

// [test/tx_descriptor_parser_asserts.sv]
// Port checker for the transmit descriptor parser
`timescale 1ns/100ps
module tx_descriptor_parser_asserts
	import txd_pkg::*;
(
	// Clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	// Memory and segment ports
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [63:0] o_mem_addr,
	input wire logic [31:0] o_mem_wdata,
	input wire logic        i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic        o_seg_valid,
	input wire logic [63:0] o_seg_addr,
	input wire logic [15:0] o_seg_len,
	input wire logic        o_segmentation_offload_request,
	input wire logic [10:0] o_segment_size_limit,
	input wire logic        o_ip_header_sum_request,
	input wire logic        o_datagram_sum_request,
	input wire logic        o_stream_sum_request,
	input wire logic        o_tag_insert_enable,
	input wire logic [15:0] o_tag_proto_id,
	input wire logic [15:0] o_tag_control_info,
	input wire logic [11:0] o_vlan_id,
	input wire logic [2:0]  o_user_priority,
	input wire logic        o_canonical_format_bit,
	input wire logic        i_seg_done
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	property p_wb_form;
		o_mem_req && o_mem_we |-> !o_mem_wdata[OWN_BIT] && o_mem_wdata[27:0] == 28'h0;
	endproperty
	a_wb_form: assert property (p_wb_form)
		else $error("write-back word malformed");
	property p_proto;
		o_seg_valid |-> o_tag_proto_id == (o_tag_insert_enable ? TAG_PROTO_ID : 16'h0);
	endproperty
	a_proto: assert property (p_proto)
		else $error("tag type value wrong");
	property p_tag_split;
		o_seg_valid |-> o_vlan_id == {o_tag_control_info[3:0], o_tag_control_info[15:8]}
			&& o_user_priority == o_tag_control_info[7:5]
			&& o_canonical_format_bit == o_tag_control_info[4];
	endproperty
	a_tag_split: assert property (p_tag_split)
		else $error("tag control split wrong");
	property p_sum_off;
		o_seg_valid && o_segmentation_offload_request |-> !o_ip_header_sum_request
			&& !o_datagram_sum_request && !o_stream_sum_request;
	endproperty
	a_sum_off: assert property (p_sum_off)
		else $error("sum request with offload layout");
	property p_limit_zero;
		o_seg_valid && !o_segmentation_offload_request |-> o_segment_size_limit == 11'h0;
	endproperty
	a_limit_zero: assert property (p_limit_zero)
		else $error("segment limit in normal layout");
	property p_seg_hold;
		o_seg_valid && !i_seg_done |=> o_seg_valid && $stable(o_seg_addr) && $stable(o_seg_len);
	endproperty
	a_seg_hold: assert property (p_seg_hold)
		else $error("segment dropped or changed early");
	property p_wb_after_done;
		o_seg_valid && i_seg_done |=> !o_seg_valid && o_mem_req && o_mem_we;
	endproperty
	a_wb_after_done: assert property (p_wb_after_done)
		else $error("no write-back after done");
	property p_fetch_seq;
		i_mem_ack && !o_mem_we && o_mem_addr[3:0] != 4'hC
			&& (o_mem_addr[3:0] != 4'h0 || i_mem_rdata[OWN_BIT])
			|=> !o_mem_req ##1 o_mem_req && !o_mem_we && o_mem_addr == $past(o_mem_addr, 2) + 64'h4;
	endproperty
	a_fetch_seq: assert property (p_fetch_seq)
		else $error("descriptor words out of order");
	property p_stop_own;
		i_mem_ack && !o_mem_we && o_mem_addr[3:0] == 4'h0 && !i_mem_rdata[OWN_BIT]
			|=> (!o_mem_req && !o_seg_valid) [*2];
	endproperty
	a_stop_own: assert property (p_stop_own)
		else $error("fetch went on past host descriptor");

	c_offload: cover property (o_seg_valid && o_segmentation_offload_request);
	c_tag: cover property (o_seg_valid && o_tag_insert_enable);
	c_stop: cover property (i_mem_ack && !o_mem_we && !i_mem_rdata[OWN_BIT]);
endmodule

bind tx_descriptor_parser tx_descriptor_parser_asserts u_chk (.*);

// [test/test_tx_descriptor_parser.sv]
// Self-checking bench for the transmit descriptor parser
`timescale 1ns/100ps
module test_tx_descriptor_parser
	import txd_pkg::*;
;
	logic        sys_clk, rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready, seg_done, slow;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, mem_req, mem_we, mem_ack;
	logic        seg_valid, first_seg, last_seg, off, ip, udp, tcp, tag, canon;
	logic [7:0]  aw_addr, ar_addr;
	logic [1:0]  b_resp, r_resp;
	logic [31:0] w_data, r_data, mem_wdata, mem_rdata;
	logic [63:0] mem_addr, seg_addr;
	logic [15:0] seg_len, proto, tci;
	logic [10:0] seg_limit;
	logic [11:0] vlan_id;
	logic [2:0]  pri_lvl;
	logic [31:0] d [3][4];
	int          miscompares, num_checks;
	integer      seed;

	tx_descriptor_parser u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
		.i_awaddr(aw_addr), .i_awvalid(aw_valid), .o_awready(aw_ready), .i_wdata(w_data),
		.i_wstrb(4'hF), .i_wvalid(w_valid), .o_wready(w_ready), .o_bresp(b_resp),
		.o_bvalid(b_valid), .i_bready(b_ready), .i_araddr(ar_addr), .i_arvalid(ar_valid),
		.o_arready(ar_ready), .o_rdata(r_data), .o_rresp(r_resp), .o_rvalid(r_valid),
		.i_rready(r_ready), .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
		.o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
		.o_seg_valid(seg_valid), .o_seg_addr(seg_addr), .o_seg_len(seg_len),
		.o_first_segment_marker(first_seg), .o_last_segment_marker(last_seg),
		.o_segmentation_offload_request(off), .o_segment_size_limit(seg_limit),
		.o_ip_header_sum_request(ip), .o_datagram_sum_request(udp), .o_stream_sum_request(tcp),
		.o_tag_insert_enable(tag), .o_tag_proto_id(proto), .o_tag_control_info(tci),
		.o_vlan_id(vlan_id), .o_user_priority(pri_lvl), .o_canonical_format_bit(canon),
		.i_seg_done(seg_done));

	txd_mem_model u_mem (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_req(mem_req), .i_we(mem_we),
		.i_addr(mem_addr), .i_wdata(mem_wdata), .i_slow(slow), .o_ack(mem_ack),
		.o_rdata(mem_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	function automatic logic [145:0] f_seg(input logic [31:0] w0, w1, w2, w3);
		logic o;
		logic t;
		o = w0[SEG_OFFLOAD_BIT];
		t = w1[TAG_INSERT_BIT];
		f_seg = {w3, w2, w0[15:0], w0[29:28], o, o ? w0[26:16] : 11'h0,
			o ? 3'h0 : w0[18:16], t, t ? TAG_PROTO_ID : 16'h0, t ? w1[15:0] : 16'h0,
			t ? {w1[3:0], w1[15:8], w1[7:5], w1[4]} : 16'h0};
	endfunction

	task automatic chk_seg(input logic [145:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED segment expected %h seen %h", e, g);
		end
	endtask

	task automatic chk_word(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		int n;
		@(posedge sys_clk);
		aw_addr <= a;
		w_data <= v;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		b_ok = 1'b0;
		for (n = 0; n < 100 && !b_ok; n++) begin
			@(negedge sys_clk);
			aw_ok = aw_valid && aw_ready;
			w_ok = w_valid && w_ready;
			b_ok = b_valid;
			r = b_resp;
			@(posedge sys_clk);
			if (aw_ok) aw_valid <= 1'b0;
			if (w_ok) w_valid <= 1'b0;
		end
		b_ready <= 1'b0;
		if (!b_ok) miscompares++;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ar_ok, r_ok;
		int n;
		@(posedge sys_clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		r_ok = 1'b0;
		for (n = 0; n < 100 && !r_ok; n++) begin
			@(negedge sys_clk);
			ar_ok = ar_valid && ar_ready;
			r_ok = r_valid;
			v = r_data;
			r = r_resp;
			@(posedge sys_clk);
			if (ar_ok) ar_valid <= 1'b0;
		end
		r_ready <= 1'b0;
		if (!r_ok) miscompares++;
	endtask

	task automatic run_round(input int first, input int n, input logic s, input logic corner);
		int idx, k, t;
		logic [31:0] v;
		logic [1:0] r;
		slow <= s;
		for (k = 0; k < n; k++) begin
			idx = (first + k) % 3;
			d[idx][0] = $random(seed) | 32'h8000_0000;
			d[idx][0][RING_END_BIT] = (idx == 2);
			if (d[idx][0][15:0] < MIN_BUF_LEN) d[idx][0][15:0] = MIN_BUF_LEN;
			d[idx][1] = corner ? ((k == 1) ? 32'h0 : 32'hFFFF_FFFF) : $random(seed);
			d[idx][2] = $random(seed);
			d[idx][3] = $random(seed);
			// Minimum length, offload at full limit, and reserved bits all set
			if (corner) d[idx][0] = (k == 0) ? 32'hA004_0004 : (k == 1) ? 32'h8FFF_0040
				: 32'hD7FB_FFFF;
			for (t = 3; t >= 0; t--) u_mem.mem[idx * 4 + t] = d[idx][t];
		end
		axi_wr(REG_POLL, 32'h1, r);
		for (k = 0; k < n; k++) begin
			idx = (first + k) % 3;
			t = 0;
			do begin
				@(negedge sys_clk);
				t++;
			end while (seg_valid !== 1'b1 && t < 500);
			chk_seg(f_seg(d[idx][0], d[idx][1], d[idx][2], d[idx][3]), {seg_addr, seg_len,
				first_seg, last_seg, off, seg_limit, ip, udp, tcp, tag, proto, tci, vlan_id,
				pri_lvl, canon});
			@(posedge sys_clk);
			repeat ($unsigned($random(seed)) % 4) @(posedge sys_clk);
			seg_done <= 1'b1;
			@(posedge sys_clk);
			seg_done <= 1'b0;
		end
		t = 0;
		do begin
			@(negedge sys_clk);
			t++;
		end while (!(mem_ack === 1'b1 && mem_we === 1'b0
			&& mem_addr[5:0] === 6'((first + n) % 3 * 16)) && t < 500);
		t = 0;
		do begin
			axi_rd(REG_STATUS, v, r);
			t++;
		end while (!(v[17] === 1'b1 && v[16] === 1'b0) && t < 50);
		chk_word("stop_index", 32'((first + n) % 3), {16'h0, v[15:0]});
		chk_word("short_flag", 32'h0, {31'h0, v[18]});
		for (k = 0; k < n; k++) begin
			idx = (first + k) % 3;
			chk_word("status_form", {1'b0, d[idx][0][30:28], 28'h0},
				u_mem.mem[idx * 4]);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#2000000;
		miscompares++;
		give_verdict();
	end

	initial begin
		logic [31:0] v;
		logic [1:0] r;
		int k;
		{rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready, seg_done, slow} = 8'h00;
		{aw_addr, ar_addr, w_data} = 48'h0;
		seed = 32'h1b63;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		axi_rd(REG_STATUS, v, r);
		chk_word("status_reset", 32'h0, v);
		axi_wr(REG_BASE_HI, 32'h1234_5678, r);
		axi_rd(REG_BASE_HI, v, r);
		chk_word("base_hi", 32'h1234_5678, v);
		axi_wr(8'h14, 32'h1, r);
		chk_word("bresp_unmapped", {30'h0, RESP_ERR}, {30'h0, r});
		axi_rd(8'h14, v, r);
		chk_word("rresp_unmapped", {30'h0, RESP_ERR}, {30'h0, r});
		chk_word("rdata_unmapped", 32'h0, v);
		axi_wr(REG_BASE_LO, BASE_RST, r);
		axi_wr(REG_CTRL, 32'h1, r);
		axi_rd(REG_CTRL, v, r);
		chk_word("ctrl", 32'h1, v);
		run_round(0, 3, 1'b0, 1'b1);
		for (k = 1; k < 4; k++) run_round(0, 3, k[0], 1'b0);
		// Stop mid-ring at a host descriptor, then resume from it
		run_round(0, 1, 1'b1, 1'b0);
		run_round(1, 2, 1'b0, 1'b0);
		give_verdict();
	end
endmodule
